// ===== pkg/gate_drive_pkg.sv
// constants for the three-phase gate drive control block
package gate_drive_pkg;
  localparam int          NUM_PHASES     = 3;
  localparam int          DEAD_W         = 8;
  localparam logic [7:0]  DEAD_RESET     = 8'h04;
  localparam int          RESET_DELAY_NS = 77;
  localparam int          CLK_PERIOD_NS  = 4;
  // longest time rounds down, at least one cycle
  localparam int          RESET_CYCLES   = (RESET_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (RESET_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [1:0]  PH_IDLE        = 2'h0;
  localparam logic [1:0]  PH_LOW         = 2'h1;
  localparam logic [1:0]  PH_HIGH        = 2'h2;
  localparam logic [1:0]  CFG_OVR_DEAD   = 2'h1;
  localparam logic [1:0]  CFG_OVR_LOCK   = 2'h2;
endpackage

// ===== sim/mcu_model.sv
// controller model: turns drive intents into request pins
`timescale 1ns/1ns
module mcu_model (
  // clock and enable state
  input  wire logic       mclk,
  input  wire logic       en,
  // intents and pins
  input  wire logic [2:0] want_low,
  input  wire logic [2:0] want_high,
  output logic      [2:0] low_req,
  output logic      [2:0] high_req_n
);
  logic [2:0] charged_q;
  // bootstrap empties while disabled, so high side waits for a low pulse
  always_ff @(posedge mclk) charged_q <= en ? (charged_q | want_low) : 3'h0;
  assign low_req    = want_low;
  assign high_req_n = ~(want_high & charged_q);
endmodule

// ===== sim/tb.sv
// self-checking bench for the gate drive control block
`timescale 1ns/1ns
module tb;
  logic        mclk = 0, resetn = 0, en1 = 0, en2 = 0, dov = 0, lov = 0, clr = 0, csn = 1, sdi = 0, occ = 0;
  logic [7:0]  dt = gate_drive_pkg::DEAD_RESET, m0 = 8'h00, m1 = 8'h00;
  logic [2:0]  wl = 3'h0, wh = 3'h0, hsc = 3'h0, lr, hrn, lo, hi;
  logic [15:0] fev = 16'h0000;
  logic        so, oen, pd, rel, bias, sa, sb, sc, ocf, irq, pg = 1;
  logic [15:0] q[$];
  int          error_cnt = 0, comparisons = 0, n;
  wire  [15:0] obs = {rel, pd, bias, irq, ocf, sc, sb, sa, hi, lo, so, oen};
  always #2 mclk = ~mclk;
  mcu_model ctl (.mclk(mclk), .en(en1 & en2), .want_low(wl), .want_high(wh), .low_req(lr), .high_req_n(hrn));
  three_phase_gate_drive_control dut (.mclk(mclk), .resetn(resetn), .clk_en(1'b1), .power_good(pg),
    .phase_a_low_request(lr[0]), .phase_b_low_request(lr[1]), .phase_c_low_request(lr[2]),
    .phase_a_high_request_n(hrn[0]), .phase_b_high_request_n(hrn[1]), .phase_c_high_request_n(hrn[2]),
    .drive_enable_first(en1), .drive_enable_second(en2), .dead_time_cfg(dt), .dead_override(dov),
    .lock_override(lov), .fault_mask_low(m0), .fault_mask_high(m1), .clear_interrupt(clr),
    .half_supply_cmp(hsc), .overcurrent_cmp(occ), .fault_events(fev), .chip_select_n(csn),
    .serial_data_in_core(sdi), .serial_out(so), .serial_out_oe_n(oen), .low_gate_on(lo), .high_gate_on(hi),
    .gate_release(rel), .gate_pulldown(pd), .bias_on(bias), .phase_a_half_supply_status(sa),
    .phase_b_half_supply_status(sb), .phase_c_half_supply_status(sc), .overcurrent_flag_out(ocf),
    .interrupt_out(irq));
  // serial out is a registered copy of core data while selected, low otherwise
  function automatic logic [15:0] e(input logic i, input logic [2:0] h, input logic [2:0] l);
    return {3'h1, i, occ, hsc, h, l, (csn ? 1'b0 : sdi), csn};
  endfunction
  task automatic cy(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic ex(input logic [15:0] v);
    q.push_back(v);
  endtask
  // deadtime makes the exact turn-on edge a design choice, so wait bounded
  task automatic await_g(input logic [2:0] h, input logic [2:0] l);
    n = 0;
    while ({hi, lo} !== {h, l} && n < 12) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    ex(e(1'b0, h, l));
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD obs exp %h seen %h", exp, seen);
    end
  endtask
  always @(negedge mclk) if (q.size() > 0) chk(obs, q.pop_front());
  task automatic final_report;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #4000;
    error_cnt++;
    final_report;
  end
  initial begin
    void'($urandom(32'h0197));
    cy(10); ex(16'hC001);
    resetn <= 1; en1 <= 1; en2 <= 1;
    cy(1); wl <= 3'h1;
    cy(1); ex(e(0, 3'h0, 3'h1));
    wl <= 3'h0; wh <= 3'h1;
    cy(1); ex(e(0, 3'h0, 3'h0));
    for (int i = 1; i <= dt; i++) begin
      cy(1); ex(e(0, 3'h0, 3'h0));
    end
    await_g(3'h1, 3'h0);
    dov <= 1; wh <= 3'h0; wl <= 3'h1;
    cy(1); ex(e(0, 3'h0, 3'h0));
    cy(1); ex(e(0, 3'h0, 3'h1));
    dov <= 0; wh <= 3'h1;
    cy(1); ex(e(0, 3'h0, 3'h0));
    lov <= 1; dov <= 1;
    cy(1); ex(e(0, 3'h1, 3'h1));
    lov <= 0; dov <= 0; wh <= 3'h0; wl <= 3'h7;
    await_g(3'h0, 3'h7);
    cy(1); en1 <= 0; ex(e(0, 3'h0, 3'h0));
    cy(1); en1 <= 1; en2 <= 0; ex(e(0, 3'h0, 3'h0));
    cy(1); en2 <= 1;
    await_g(3'h0, 3'h7);
    fev <= 16'h0008;
    cy(1); fev <= 16'h0000; ex(e(1, 3'h0, 3'h7));
    cy(2); ex(e(1, 3'h0, 3'h7)); clr <= 1;
    cy(1); clr <= 0; ex(e(0, 3'h0, 3'h7)); m1 <= 8'h01;
    cy(1); fev <= 16'h0100;
    cy(1); fev <= 16'h0000;
    cy(1); ex(e(0, 3'h0, 3'h7)); fev <= 16'h0001; clr <= 1;
    cy(1); fev <= 16'h0000; ex(e(1, 3'h0, 3'h7));
    cy(1); clr <= 0; ex(e(0, 3'h0, 3'h7)); wl <= 3'h0;
    for (int i = 0; i < 12; i++) begin
      {hsc, occ, csn, sdi} <= 6'($urandom);
      cy(1); ex(e(0, 3'h0, 3'h0));
    end
    hsc <= 3'h0; occ <= 0; csn <= 1; wl <= 3'h7; pg <= 0;
    cy(1); ex(16'hC001);
    pg <= 1;
    cy(1); ex(e(0, 3'h0, 3'h7)); resetn <= 0;
    cy(1); ex(16'hC001);
    cy(2); final_report;
  end
endmodule

// ===== verilog/three_phase_gate_drive_control.sv
// three-phase predriver control logic: gate qualification, interlock, deadtime, status
`timescale 1ns/1ns
// Notes on behaviour
// - serial data output is released unless chip select is low.
// - low-side request inputs are active high.
// - high-side request inputs are active low.
// - overcurrent comparator result goes out as a driven logic output.
// - deadtime and interlock keep both drivers of a phase from being on together unless both overrides are set.
// - controller sets deadtime and override modes; block applies them.
// - phase status low while high-side source is below half supply.
// - gates may turn on only while both enables are high.
// - either enable low forces all six gates off; other logic continues.
// - enables act without waiting for a clock edge.
// - reset low gives low power: outputs off, bias off, gate pull-down.
// - internal logic is reset within 77 ns of reset falling.
// - fault drives interrupt high until cleared; two masks gate fault sources.
// - overcurrent output high means overcurrent, low means none.
// - before power-good, logic held reset, drivers released, serial refused.
module three_phase_gate_drive_control #(
  parameter int DEAD_WIDTH = gate_drive_pkg::DEAD_W
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  clk_en,
  input  wire logic                  power_good,
  // phase requests
  input  wire logic                  phase_a_low_request,
  input  wire logic                  phase_b_low_request,
  input  wire logic                  phase_c_low_request,
  input  wire logic                  phase_a_high_request_n,
  input  wire logic                  phase_b_high_request_n,
  input  wire logic                  phase_c_high_request_n,
  input  wire logic                  drive_enable_first,
  input  wire logic                  drive_enable_second,
  // configuration from the serial port
  input  wire logic [DEAD_WIDTH-1:0] dead_time_cfg,
  input  wire logic                  dead_override,
  input  wire logic                  lock_override,
  input  wire logic [7:0]            fault_mask_low,
  input  wire logic [7:0]            fault_mask_high,
  input  wire logic                  clear_interrupt,
  // analog comparator results
  input  wire logic [2:0]            half_supply_cmp,
  input  wire logic                  overcurrent_cmp,
  input  wire logic [15:0]           fault_events,
  // serial output path
  input  wire logic                  chip_select_n,
  input  wire logic                  serial_data_in_core,
  output logic                       serial_out,
  output logic                       serial_out_oe_n,
  // gate drives
  output logic [2:0]                 low_gate_on,
  output logic [2:0]                 high_gate_on,
  output logic                       gate_release,
  output logic                       gate_pulldown,
  output logic                       bias_on,
  // status
  output logic                       phase_a_half_supply_status,
  output logic                       phase_b_half_supply_status,
  output logic                       phase_c_half_supply_status,
  output logic                       overcurrent_flag_out,
  output logic                       interrupt_out
);
  typedef enum logic [1:0] {
    PS_IDLE = gate_drive_pkg::PH_IDLE,
    PS_LOW  = gate_drive_pkg::PH_LOW,
    PS_HIGH = gate_drive_pkg::PH_HIGH
  } phase_state_t;

  typedef struct packed {
    phase_state_t [2:0]        ph;
    logic [2:0][DEAD_WIDTH-1:0] dead;
    logic [2:0]                lo;
    logic [2:0]                hi;
    logic [2:0]                stat;
    logic                      oc;
    logic                      irq;
    logic                      so;
    logic                      so_oe_n;
    logic                      active;
  } state_t;

  state_t q, d;
  logic [2:0] low_req;
  logic [2:0] high_req;
  logic       enabled;
  logic       run;

  assign low_req  = {phase_c_low_request, phase_b_low_request, phase_a_low_request};
  assign high_req = ~{phase_c_high_request_n, phase_b_high_request_n, phase_a_high_request_n};
  assign run      = resetn & power_good;

  // gates use the enables directly, so turn-off does not wait for mclk
  assign enabled = drive_enable_first & drive_enable_second;

  always_comb begin
    logic conflict;
    logic want_lo;
    logic want_hi;
    conflict = 1'b0;
    want_lo  = 1'b0;
    want_hi  = 1'b0;
    d = q;
    d.active = 1'b1;
    for (int p = 0; p < 3; p++) begin
      conflict = low_req[p] & high_req[p] & ~lock_override;
      want_lo  = low_req[p] & ~conflict;
      want_hi  = high_req[p] & ~conflict;
      if (lock_override) begin
        want_hi = high_req[p];
      end else if (want_lo) begin
        want_hi = 1'b0;
      end
      if (q.dead[p] != '0) begin
        d.dead[p] = q.dead[p] - 1'b1;
      end
      unique case (q.ph[p])
        PS_IDLE: begin
          if (want_lo && (q.dead[p] == '0 || dead_override)) begin
            d.ph[p] = PS_LOW;
          end else if (want_hi && (q.dead[p] == '0 || dead_override)) begin
            d.ph[p] = PS_HIGH;
          end
        end
        PS_LOW: begin
          if (!want_lo) begin
            d.ph[p]   = PS_IDLE;
            d.dead[p] = dead_time_cfg;
          end
        end
        PS_HIGH: begin
          if (!want_hi) begin
            d.ph[p]   = PS_IDLE;
            d.dead[p] = dead_time_cfg;
          end
        end
        default: begin
          // unused code: fall back to both drivers off
          d.ph[p] = PS_IDLE;
        end
      endcase
      d.lo[p] = (d.ph[p] == PS_LOW) | (lock_override & dead_override & low_req[p]);
      d.hi[p] = (d.ph[p] == PS_HIGH) | (lock_override & dead_override & high_req[p]);
    end
    d.stat = half_supply_cmp;
    d.oc   = overcurrent_cmp;
    // set wins over a clear in the same cycle
    if (|(fault_events & ~{fault_mask_high, fault_mask_low})) begin
      d.irq = 1'b1;
    end else if (clear_interrupt) begin
      d.irq = 1'b0;
    end
    d.so_oe_n = chip_select_n;
    d.so      = chip_select_n ? 1'b0 : serial_data_in_core;
    if (!run) begin
      d = '0;
      d.so_oe_n = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!run) begin
      q <= d; // one edge resets, well inside the allowed delay
    end else if (clk_en) begin
      q <= d;
    end
  end

  // enables gate the registered drives combinationally; limitation accepted for async off
  assign low_gate_on   = q.lo & {3{enabled}};
  assign high_gate_on  = q.hi & {3{enabled}};
  assign gate_release  = ~q.active;
  assign gate_pulldown = ~q.active;
  assign bias_on       = q.active;
  assign phase_a_half_supply_status = q.stat[0];
  assign phase_b_half_supply_status = q.stat[1];
  assign phase_c_half_supply_status = q.stat[2];
  assign overcurrent_flag_out = q.oc;
  assign interrupt_out   = q.irq;
  assign serial_out      = q.so;
  assign serial_out_oe_n = q.so_oe_n;

  // never both gates of one phase unless both overrides set; gates are registered, so check one edge later
  gate_exclusive_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && !(lock_override && dead_override)) |=> ((low_gate_on & high_gate_on) == 3'h0))
    else $error("both gates of a phase on");
  enable_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    !enabled |-> (low_gate_on == 3'h0 && high_gate_on == 3'h0))
    else $error("gate on while disabled");
  reset_quiet_a: assert property (@(posedge mclk)
    !resetn |=> (!interrupt_out && serial_out_oe_n && gate_pulldown))
    else $error("reset not reached");
  so_release_a: assert property (@(posedge mclk) disable iff (!run)
    (clk_en && chip_select_n) |=> serial_out_oe_n)
    else $error("serial out driven with select high");
  irq_hold_a: assert property (@(posedge mclk) disable iff (!run)
    (interrupt_out && !clear_interrupt && clk_en) |=> interrupt_out)
    else $error("interrupt dropped without clear");
  oc_follow_a: assert property (@(posedge mclk) disable iff (!run)
    clk_en |=> (overcurrent_flag_out == $past(overcurrent_cmp)))
    else $error("overcurrent output wrong");
  status_follow_a: assert property (@(posedge mclk) disable iff (!run)
    clk_en |=> (phase_a_half_supply_status == $past(half_supply_cmp[0])))
    else $error("phase status wrong");
  conflict_off_a: assert property (@(posedge mclk) disable iff (!run)
    (clk_en && !lock_override && low_req[0] && high_req[0]) |=> (!q.lo[0] && !q.hi[0]))
    else $error("conflict not blanked");
endmodule
